// ===== dfd_flag_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module dfd_flag_decoder
   import dfd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic accept_i,
   input wire logic [FLAG_W-1:0] flags_i,
   input wire logic in_batch_i,
   input wire logic [2:0] op_i,
   input wire dfd_cap_s cap_i,
   input wire logic prior_busy_i,
   input wire logic prior_failed_i,
   input wire logic fault_i,
   input wire logic fault_on_fixed_i,
   input wire logic fault_resolved_i,
   input wire logic writes_done_i,
   input wire logic [7:0] status_i,
   input wire logic readback_done_i,
   input wire logic record_done_i,
   output logic start_o,
   output logic abandon_o,
   output logic partial_o,
   output logic waiting_fault_o,
   output logic readback_req_o,
   output logic record_req_o,
   output logic event_log_o,
   output logic sw_error_o,
   output logic done_o,
   output logic busy_o,
   output dfd_attr_s attr_o
);

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_FENCE,
      ST_RUN,
      ST_FAULT,
      ST_READBACK,
      ST_RECORD,
      ST_DONE
   } dfd_state_e;

   dfd_state_e state_ff;
   dfd_state_e nxt_state;
   dfd_attr_s attr_ff;
   dfd_attr_s nxt_attr;
   logic [7:0] status_ff;
   logic start_ff;
   logic abandon_ff;
   logic partial_ff;
   logic rb_ff;
   logic rec_ff;
   logic log_ff;
   logic swe_ff;
   logic done_ff;
   logic busy_ff;
   logic wf_ff;
   logic abn_ff;

   // Decode of the incoming flags.
   wire logic [2:0] in_cc = flags_i[FLAG_CC_LSB_POS +: 3];
   wire logic op_flush = (op_i == DFD_OP_FLUSH);
   wire logic op_nobof = (op_i == DFD_OP_NOOP) || (op_i == DFD_OP_DRAIN) || (op_i == DFD_OP_BATCH);
   wire logic in_bof_rsv = !cap_i.bof_enable || op_nobof;
   wire logic in_fence = flags_i[FLAG_FENCE_POS] && in_batch_i;
   wire logic in_rb = (in_cc == CC_DUR_RB) || (in_cc == CC_CACHE_RB) || (in_cc == CC_MEM_RB);
   wire logic in_alloc = (in_cc == CC_CACHE) || (in_cc == CC_CACHE_RB);
   wire logic in_dur = (in_cc == CC_DUR) || (in_cc == CC_DUR_RB);
   wire logic cc_rsv_cap =
      ((in_cc == CC_CACHE) && !cap_i.cache_ctrl) ||
      ((in_cc == CC_DUR_RB) && !cap_i.readback) ||
      ((in_cc == CC_CACHE_RB) && !(cap_i.cache_ctrl && cap_i.readback)) ||
      ((in_cc == CC_DUR) && !cap_i.durable_write) ||
      ((in_cc == CC_MEM_RB) && !cap_i.readback);
   wire logic cc_rsv_code = (in_cc == CC_RSV5) || (in_cc == CC_RSV7);
   wire logic cc_rsv_flush = op_flush && (in_cc != CC_MEM) && (in_cc != CC_DUR_RB);

   always_comb
   begin
      nxt_attr.fence = in_fence;
      nxt_attr.block_on_fault = flags_i[FLAG_BOF_POS] && !in_bof_rsv;
      nxt_attr.rec_addr_valid = flags_i[FLAG_CRAV_POS];
      nxt_attr.req_record = flags_i[FLAG_RCR_POS] && flags_i[FLAG_CRAV_POS];
      nxt_attr.cc = in_cc;
      nxt_attr.write_alloc = in_alloc;
      nxt_attr.durable = in_dur;
      nxt_attr.readback = in_rb;
      nxt_attr.cc_reserved = cc_rsv_cap || cc_rsv_code || cc_rsv_flush;
      nxt_attr.bof_reserved = flags_i[FLAG_BOF_POS] && in_bof_rsv;
   end

   // Completion decisions made from the held attributes.
   wire logic fin_ok = (status_ff == STS_SUCCESS);
   wire logic quiet = (status_ff == STS_SUCCESS) || (status_ff == STS_QUIET_2) || (status_ff == STS_QUIET_5);
   wire logic want_rec = attr_ff.req_record || !quiet;
   wire logic rec_ok = want_rec && attr_ff.rec_addr_valid;
   wire logic unrep = !attr_ff.rec_addr_valid && !quiet;
   wire logic do_rb = attr_ff.readback && fin_ok;
   wire logic blocks = attr_ff.block_on_fault || fault_on_fixed_i;
   wire logic stop_batch = prior_failed_i || abn_ff;
   wire logic batch_dead = abn_ff && in_batch_i;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (accept_i)
            begin
               nxt_state = (in_fence || batch_dead) ? ST_FENCE : ST_RUN;
            end
         end
         ST_FENCE:
         begin
            if (stop_batch)
            begin
               nxt_state = ST_IDLE;
            end
            else if (!prior_busy_i)
            begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (fault_i && blocks)
            begin
               nxt_state = ST_FAULT;
            end
            else if (fault_i || writes_done_i)
            begin
               nxt_state = ST_DONE;
            end
         end
         ST_FAULT:
         begin
            if (fault_resolved_i)
            begin
               nxt_state = ST_RUN;
            end
         end
         ST_DONE:
         begin
            nxt_state = do_rb ? ST_READBACK : (rec_ok ? ST_RECORD : ST_IDLE);
         end
         ST_READBACK:
         begin
            if (readback_done_i)
            begin
               nxt_state = rec_ok ? ST_RECORD : ST_IDLE;
            end
         end
         ST_RECORD:
         begin
            if (record_done_i)
            begin
               nxt_state = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   wire logic go_run = (nxt_state == ST_RUN) && (state_ff == ST_IDLE || state_ff == ST_FENCE);
   wire logic go_abandon = (state_ff == ST_FENCE) && stop_batch;
   wire logic st_partial = (state_ff == ST_RUN) && fault_i && !blocks;
   wire logic st_final = (state_ff == ST_RUN) && (fault_i || writes_done_i) && !(fault_i && blocks);
   wire logic leave = (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);

   // Once a fence is abandoned, every later descriptor of that batch is abandoned too.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         abn_ff <= 1'h0;
      end
      else if (go_abandon)
      begin
         abn_ff <= 1'h1;
      end
      else if (!in_batch_i && state_ff == ST_IDLE)
      begin
         abn_ff <= 1'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= ST_IDLE;
         attr_ff <= '0;
         status_ff <= STS_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE && accept_i)
         begin
            attr_ff <= nxt_attr;
         end
         if (st_final)
         begin
            status_ff <= status_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         start_ff <= 1'h0;
         abandon_ff <= 1'h0;
         partial_ff <= 1'h0;
         rb_ff <= 1'h0;
         rec_ff <= 1'h0;
         log_ff <= 1'h0;
         swe_ff <= 1'h0;
         done_ff <= 1'h0;
         busy_ff <= 1'h0;
         wf_ff <= 1'h0;
      end
      else
      begin
         start_ff <= go_run;
         abandon_ff <= go_abandon;
         partial_ff <= st_partial;
         rb_ff <= (nxt_state == ST_READBACK);
         rec_ff <= (nxt_state == ST_RECORD);
         log_ff <= (state_ff == ST_DONE) && unrep && cap_i.event_log_en;
         swe_ff <= (state_ff == ST_DONE) && unrep && !cap_i.event_log_en;
         done_ff <= leave;
         busy_ff <= (nxt_state != ST_IDLE);
         wf_ff <= (nxt_state == ST_FAULT);
      end
   end

   assign start_o = start_ff;
   assign abandon_o = abandon_ff;
   assign partial_o = partial_ff;
   assign waiting_fault_o = wf_ff;
   assign readback_req_o = rb_ff;
   assign record_req_o = rec_ff;
   assign event_log_o = log_ff;
   assign sw_error_o = swe_ff;
   assign done_o = done_ff;
   assign busy_o = busy_ff;
   assign attr_o = attr_ff;

   property p_fence_wait;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_FENCE && prior_busy_i && !prior_failed_i) |=> !start_o;
   endproperty
   a_fence_wait: assert property (p_fence_wait) else $error("fenced work started early");

   property p_abandon;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_FENCE && prior_failed_i) |=> abandon_o && !start_o && !busy_o;
   endproperty
   a_abandon: assert property (p_abandon) else $error("fenced work not abandoned");

   property p_batch_dead;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_IDLE && accept_i && batch_dead) |=> !start_o ##1 abandon_o;
   endproperty
   a_batch_dead: assert property (p_batch_dead) else $error("later batch work not abandoned");

   property p_no_bad_record;
      @(posedge clk_i) disable iff (rst_i)
      record_req_o |-> attr_o.rec_addr_valid;
   endproperty
   a_no_bad_record: assert property (p_no_bad_record) else $error("record to invalid address");

   property p_record_quiet;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_DONE && !do_rb && attr_ff.rec_addr_valid && !attr_ff.req_record && !quiet)
      |=> record_req_o;
   endproperty
   a_record_quiet: assert property (p_record_quiet) else $error("error record missing");

   property p_rb_success;
      @(posedge clk_i) disable iff (rst_i)
      $rose(readback_req_o) |-> attr_o.readback && $past(status_ff) == STS_SUCCESS;
   endproperty
   a_rb_success: assert property (p_rb_success) else $error("readback without success");

   sequence s_rb_finished;
      readback_req_o && readback_done_i && rec_ok;
   endsequence
   property p_rb_then_rec;
      @(posedge clk_i) disable iff (rst_i)
      s_rb_finished |=> record_req_o && !readback_req_o;
   endproperty
   a_rb_then_rec: assert property (p_rb_then_rec) else $error("record did not follow readback");

   property p_rb_order;
      @(posedge clk_i) disable iff (rst_i)
      $rose(record_req_o) && attr_o.readback && $past(status_ff) == STS_SUCCESS |-> $past(readback_req_o);
   endproperty
   a_rb_order: assert property (p_rb_order) else $error("record before readback");

   property p_fixed_block;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_RUN && fault_i && fault_on_fixed_i) |=> waiting_fault_o && !partial_o;
   endproperty
   a_fixed_block: assert property (p_fixed_block) else $error("fixed fault did not block");

   property p_partial;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_RUN && fault_i && !fault_on_fixed_i && !attr_ff.block_on_fault) |=> partial_o;
   endproperty
   a_partial: assert property (p_partial) else $error("fault not partial");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      (busy_o && $past(busy_o)) |-> $stable(attr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("attributes changed in flight");

   property p_bof_rsv;
      @(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_IDLE && accept_i && in_bof_rsv) |=> !attr_o.block_on_fault;
   endproperty
   a_bof_rsv: assert property (p_bof_rsv) else $error("reserved block flag honoured");

   property p_log;
      @(posedge clk_i) disable iff (rst_i)
      (event_log_o || sw_error_o) |-> !attr_o.rec_addr_valid && !(event_log_o && sw_error_o);
   endproperty
   a_log: assert property (p_log) else $error("error log misrouted");

endmodule // dfd_flag_decoder
`default_nettype wire

// ===== dfd_pkg.sv
package dfd_pkg;

   // Descriptor flag bit positions.
   localparam int unsigned FLAG_FENCE_POS = 0;
   localparam int unsigned FLAG_BOF_POS = 1;
   localparam int unsigned FLAG_CRAV_POS = 2;
   localparam int unsigned FLAG_RCR_POS = 3;
   localparam int unsigned FLAG_CC_LSB_POS = 4;
   localparam int unsigned FLAG_W = 7;

   // Final status codes that suppress the record when none was requested.
   localparam logic [7:0] STS_SUCCESS = 8'h01;
   localparam logic [7:0] STS_QUIET_2 = 8'h02;
   localparam logic [7:0] STS_QUIET_5 = 8'h05;

   // Cache-control codes.
   localparam logic [2:0] CC_MEM = 3'h0;
   localparam logic [2:0] CC_CACHE = 3'h1;
   localparam logic [2:0] CC_DUR_RB = 3'h2;
   localparam logic [2:0] CC_CACHE_RB = 3'h3;
   localparam logic [2:0] CC_DUR = 3'h4;
   localparam logic [2:0] CC_RSV5 = 3'h5;
   localparam logic [2:0] CC_MEM_RB = 3'h6;
   localparam logic [2:0] CC_RSV7 = 3'h7;

   // Operation class of the descriptor, as decoded upstream.
   typedef enum logic [2:0]
   {
      DFD_OP_DATA,
      DFD_OP_NOOP,
      DFD_OP_DRAIN,
      DFD_OP_BATCH,
      DFD_OP_FLUSH
   } dfd_op_e;

   // Capability and queue configuration bits.
   typedef struct packed
   {
      logic cache_ctrl;
      logic durable_write;
      logic readback;
      logic bof_enable;
      logic event_log_en;
   } dfd_cap_s;

   // Decoded attributes held for the lifetime of one descriptor.
   typedef struct packed
   {
      logic fence;
      logic block_on_fault;
      logic rec_addr_valid;
      logic req_record;
      logic [2:0] cc;
      logic write_alloc;
      logic durable;
      logic readback;
      logic cc_reserved;
      logic bof_reserved;
   } dfd_attr_s;

   // Reset value of the completion status byte.
   localparam logic [7:0] STS_RESET = 8'h00;

endpackage

// ===== dfd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory-side engine: answers readback first, then the record, after lat_i + 1 cycles.
module dfd_mem_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] lat_i,
   input wire logic rb_req_i,
   input wire logic rec_req_i,
   output logic rb_done_o,
   output logic rec_done_o
);
   logic [3:0] cnt_ff;
   always_ff @(posedge clk_i)
   begin
      rb_done_o <= 1'h0;
      rec_done_o <= 1'h0;
      if (rst_i || !(rb_req_i || rec_req_i) || rb_done_o || rec_done_o)
         cnt_ff <= 4'h0;
      else if (cnt_ff == lat_i)
      begin
         rb_done_o <= rb_req_i;
         // The record lands as one aligned 32-byte write, so a single answer retires it.
         rec_done_o <= !rb_req_i;
      end
      else
         cnt_ff <= cnt_ff + 4'h1;
   end
endmodule // dfd_mem_model
`default_nettype wire

// ===== tb_descriptor_flag_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_descriptor_flag_decoder
   import dfd_pkg::*;
;
   logic clk_i = '0, rst_i = '1, acc = '0, inb = '0, pb = '0, pf = '0;
   logic flt = '0, ffix = '0, fres = '0, wd = '0;
   logic [6:0] fl = '0;
   logic [2:0] op = '0;
   logic [7:0] st = '0;
   logic [3:0] lat = 4'h1;
   dfd_cap_s cap = '1;
   logic rbd, rcd, start, aband, part, wf, rbq, rcq, evl, swe, done, busy;
   dfd_attr_s attr;
   logic sv_rb, sv_rc, sv_ev, sv_sw, sv_pt, sv_wf, sv_ab, sv_dn, ord;
   int fails = 0, n_checks = 0, cyc = 0, ts, t0;

   dfd_flag_decoder dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .accept_i(acc), .flags_i(fl), .in_batch_i(inb), .op_i(op),
      .cap_i(cap), .prior_busy_i(pb), .prior_failed_i(pf), .fault_i(flt), .fault_on_fixed_i(ffix),
      .fault_resolved_i(fres), .writes_done_i(wd), .status_i(st), .readback_done_i(rbd),
      .record_done_i(rcd), .start_o(start), .abandon_o(aband), .partial_o(part),
      .waiting_fault_o(wf), .readback_req_o(rbq), .record_req_o(rcq), .event_log_o(evl),
      .sw_error_o(swe), .done_o(done), .busy_o(busy), .attr_o(attr)
   );
   dfd_mem_model mem
   (
      .clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .rb_req_i(rbq), .rec_req_i(rcq),
      .rb_done_o(rbd), .rec_done_o(rcd)
   );

   always #5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         fails = fails + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic ck(input logic c, input string m);
      n_checks++;
      if (c !== 1'h1)
      begin
         fails++;
         $display("Error %0t: %s", $time, m);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   function automatic logic rsv(logic [2:0] c, dfd_cap_s k);
      return c == 3'h5 || c == 3'h7 || (c[0] && !k.cache_ctrl) || (c[1] && !k.readback)
         || (c == 3'h4 && !k.durable_write);
   endfunction

   // One descriptor from acceptance to retirement; a fault replaces writes_done when fk is set.
   task automatic run(input logic [6:0] f, input logic [7:0] s, input logic fk);
      {sv_rb, sv_rc, sv_ev, sv_sw, sv_pt, sv_wf, sv_ab, sv_dn, ord} = '0;
      fl = f;
      acc = 1'h1;
      step(1);
      acc = 1'h0;
      for (int i = 0; i < 30 && start !== 1'h1 && aband !== 1'h1; i++)
         step(1);
      ts = cyc;
      sv_ab = aband === 1'h1;
      sv_dn = done === 1'h1;
      fl = ~f;
      st = s;
      if (fk)
         flt = 1'h1;
      else
         wd = 1'h1;
      step(1);
      {flt, wd} = '0;
      for (int i = 0; i < 40; i++)
      begin
         if (rcq === 1'h1 && !sv_rc)
            ord = sv_rb;
         sv_rb |= rbq === 1'h1;
         sv_rc |= rcq === 1'h1;
         sv_ev |= evl === 1'h1;
         sv_sw |= swe === 1'h1;
         sv_pt |= part === 1'h1;
         sv_dn |= done === 1'h1;
         if (busy !== 1'h1)
            break;
         if (wf === 1'h1)
         begin
            sv_wf = 1'h1;
            fres = 1'h1;
            step(1);
            fres = 1'h0;
            wd = 1'h1;
         end
         step(1);
         wd = 1'h0;
      end
      ck(attr.cc === f[6:4] && attr.rec_addr_valid === f[2], "attributes changed in flight");
      ck(sv_dn === 1'h1, "descriptor not retired");
   endtask

   task automatic t_record();
      logic [7:0] sts [5] = '{8'h01, 8'h02, 8'h05, 8'h03, 8'hFF};
      foreach (sts[i])
      begin
         for (int r = 0; r < 2; r++)
         begin
            run({3'h0, r[0], 3'h4}, sts[i], 1'h0);
            ck(sv_rc === (r == 1 || i > 2), "record policy");
         end
         cap.event_log_en = i[0];
         run(7'h00, sts[i], 1'h0);
         ck(!sv_rc && sv_ev === (i > 2 && i[0]) && sv_sw === (i > 2 && !i[0]), "unreported error");
      end
      cap = '1;
   endtask

   task automatic t_cc();
      for (int p = 0; p < 2; p++)
      begin
         cap = p ? '0 : '1;
         lat = p ? 4'h6 : 4'h1;
         for (int c = 0; c < 8; c++)
         begin
            run({c[2:0], 4'hC}, 8'h01, 1'h0);
            ck(attr.cc_reserved === rsv(c[2:0], cap), "reserved code");
            if (p == 0)
            begin
               ck(attr.write_alloc === (c == 1 || c == 3), "allocate");
               ck(attr.durable === (c == 2 || c == 4), "durable");
               ck(sv_rb === (c inside {2, 3, 6}) && ord === sv_rb, "readback order");
            end
         end
      end
      cap = '1;
      op = DFD_OP_FLUSH;
      run(7'h1C, 8'h01, 1'h0);
      ck(attr.cc_reserved === 1'h1, "flush code 1");
      run(7'h2C, 8'h01, 1'h0);
      ck(attr.cc_reserved === 1'h0, "flush code 2");
      run(7'h0C, 8'h01, 1'h0);
      ck(attr.cc_reserved === 1'h0, "flush code 0");
      op = DFD_OP_DATA;
      run(7'h6C, 8'h03, 1'h0);
      ck(sv_rb === 1'h0, "readback on failure");
   endtask

   task automatic t_fault();
      run(7'h6C, 8'h03, 1'h1);
      ck(sv_pt && !sv_rb && !sv_wf, "non-blocking fault");
      run(7'h6E, 8'h01, 1'h1);
      ck(sv_wf && !sv_pt && sv_rb, "blocking fault");
      ck(attr.bof_reserved === 1'h0, "block flag allowed");
      ffix = 1'h1;
      run(7'h6C, 8'h01, 1'h1);
      ffix = 1'h0;
      ck(sv_wf && !sv_pt, "fixed address fault");
      op = DFD_OP_NOOP;
      run(7'h02, 8'h01, 1'h0);
      ck(attr.bof_reserved === 1'h1, "block flag on no-op");
      op = DFD_OP_DATA;
      cap.bof_enable = 1'h0;
      run(7'h02, 8'h01, 1'h0);
      ck(attr.bof_reserved === 1'h1, "block flag disabled");
      cap = '1;
   endtask

   task automatic t_fence();
      inb = 1'h1;
      pb = 1'h1;
      fork
         run(7'h0D, 8'h01, 1'h0);
         begin
            step(6);
            t0 = cyc;
            pb = 1'h0;
         end
      join
      ck(ts > t0, "fence wait");
      pb = 1'h1;
      t0 = cyc;
      run(7'h0C, 8'h01, 1'h0);
      ck(ts - t0 < 4, "unfenced start");
      pb = 1'h0;
      pf = 1'h1;
      run(7'h0D, 8'h01, 1'h0);
      ck(sv_ab === 1'h1, "fenced abandon");
      run(7'h0C, 8'h01, 1'h0);
      ck(sv_ab === 1'h1, "later abandon");
      {pf, inb} = '0;
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      #1;
      rst_i = 1'h0;
      t_record();
      t_cc();
      t_fault();
      t_fence();
      report_and_stop();
   end
endmodule // tb_descriptor_flag_decoder
`default_nettype wire
